// ### dv/ddsr_host_model.sv
// Host side of the serial port: frames instruction and data bits
`timescale 1ns/10ps
module ddsr_host_model (
  // Clock
  input wire i_sys_clk,
  // Serial pins
  output logic o_sclk,
  output logic o_cs_b,
  output logic o_sdio,
  input wire i_dout
);
  // Six clocks a phase leaves margin over the three-clock sync minimum
  task automatic xfer(input logic rd, input logic [4:0] a, input logic [31:0] d, input int n,
                      input logic lsb, output logic [31:0] q);
    logic [7:0] ins;
    int k;
    ins = {rd, 2'b00, a};
    q = 32'h0;
    o_cs_b <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    for (int i = 0; i < n + 8; i++) begin
      k = (i < 8) ? (lsb ? i : 7 - i) : (lsb ? i - 8 : n + 7 - i);
      o_sdio <= (i < 8) ? ins[k] : d[k];
      repeat (6) @(posedge i_sys_clk);
      if (i >= 8) q[k] = i_dout;
      o_sclk <= 1'b1;
      repeat (6) @(posedge i_sys_clk);
      o_sclk <= 1'b0;
    end
    repeat (8) @(posedge i_sys_clk);
    o_cs_b <= 1'b1;
    o_sdio <= ~o_sdio; // Released line shows the inverse
    repeat (4) @(posedge i_sys_clk);
  endtask
  // Idle pins
  initial begin
    o_sclk = 1'b0;
    o_cs_b = 1'b1;
    o_sdio = 1'b0;
  end
endmodule // ddsr_host_model

// ### dv/ddsr_props.sv
// Port assertions of the DDS register bank
`timescale 1ns/10ps
module ddsr_props (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst_b,
  // Serial pins
  input wire i_cs_b,
  input wire o_sdio,
  input wire o_sdio_oe_b,
  input wire o_sdo,
  // Bank outputs
  input wire o_pll_bypass,
  input wire [4:0] o_pll_mult,
  input wire [15:0] o_amplitude_scale,
  input wire [7:0] o_amplitude_ramp_rate,
  input wire [13:0] o_phase
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // Port deselected long enough for the sync flops to settle
  sequence s_idle;
    i_cs_b [*6];
  endsequence
  a_mult_range: assert property (!o_pll_bypass |-> o_pll_mult >= 5'h04 && o_pll_mult <= 5'h14)
    else $error("multiplier used outside its range");
  a_bypass_range: assert property (o_pll_bypass |-> o_pll_mult < 5'h04 || o_pll_mult > 5'h14)
    else $error("bypass with a valid multiplier");
  a_reset_state: assert property ($rose(i_rst_b) |-> o_pll_bypass && o_pll_mult == 5'h00
    && o_amplitude_scale == 16'h0000 && o_amplitude_ramp_rate == 8'h00 && o_phase == 14'h0000)
    else $error("bank not cleared by reset");
  a_oe_needs_cs: assert property ($fell(o_sdio_oe_b) |-> !i_cs_b)
    else $error("data pin driven while deselected");
  a_oe_idle: assert property (s_idle |-> o_sdio_oe_b)
    else $error("data pin driven while idle");
  a_pins_agree: assert property (!o_sdio_oe_b |-> o_sdio == o_sdo)
    else $error("data pins disagree");
  a_ramp_frame: assert property (!$stable(o_amplitude_ramp_rate) |-> !$past(i_cs_b, 2))
    else $error("ramp rate changed outside a frame");
  a_scale_frame: assert property (!$stable(o_amplitude_scale) |-> !$past(i_cs_b, 2))
    else $error("scale changed outside a frame");
endmodule // ddsr_props

bind ddsr_register_map ddsr_props chk_u (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_cs_b(i_cs_b),
  .o_sdio(o_sdio), .o_sdio_oe_b(o_sdio_oe_b), .o_sdo(o_sdo), .o_pll_bypass(o_pll_bypass),
  .o_pll_mult(o_pll_mult), .o_amplitude_scale(o_amplitude_scale),
  .o_amplitude_ramp_rate(o_amplitude_ramp_rate), .o_phase(o_phase));

// ### dv/tb_top.sv
// Self-checking bench of the DDS register bank
`timescale 1ns/10ps
module tb_top;
  logic i_sys_clk = 0, i_rst_b = 0, i_io_update = 0, oe_seen = 0, three = 0;
  logic sclk, cs_b, h_sdio, o_sdio, o_sdio_oe_b, o_sdo, o_pll_bypass;
  logic [4:0] o_pll_mult;
  logic [15:0] o_amplitude_scale;
  logic [7:0] o_amplitude_ramp_rate;
  logic [13:0] o_phase;
  logic [31:0] q, v;
  int fail_count = 0, num_checks = 0, cyc = 0;
  int wid [6] = '{32, 24, 16, 8, 32, 16};
  // Wire level: device wins only while it enables its driver
  wire sdio = o_sdio_oe_b ? h_sdio : o_sdio;
  wire dout = three ? o_sdo : sdio;
  ddsr_register_map dut_u (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_sclk(sclk), .i_cs_b(cs_b),
    .i_sdio(sdio), .o_sdio(o_sdio), .o_sdio_oe_b(o_sdio_oe_b), .o_sdo(o_sdo), .i_io_update(i_io_update),
    .o_pll_bypass(o_pll_bypass), .o_pll_mult(o_pll_mult), .o_amplitude_scale(o_amplitude_scale),
    .o_amplitude_ramp_rate(o_amplitude_ramp_rate), .o_phase(o_phase));
  ddsr_host_model host_u (.i_sys_clk(i_sys_clk), .o_sclk(sclk), .o_cs_b(cs_b), .o_sdio(h_sdio), .i_dout(dout));
  // Clock
  initial forever #20 i_sys_clk = ~i_sys_clk;
  // Hang guard and driver-enable monitor
  always @(posedge i_sys_clk) begin
    if (o_sdio_oe_b === 1'b0) oe_seen <= 1'b1;
    cyc++;
    if (cyc == 80000) begin
      fail_count++;
      print_verdict;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input int a, input logic [31:0] d, input logic l = 1'b0);
    host_u.xfer(1'b0, a[4:0], d, wid[a], l, q);
  endtask
  task automatic rd(input int a, input logic l = 1'b0);
    host_u.xfer(1'b1, a[4:0], 32'h0, wid[a], l, q);
  endtask
  // Stored image of a write: unused phase bits read as zero
  function automatic logic [31:0] expect_of(int a, logic [31:0] d);
    return (a == 5) ? d & 32'h3FFF : d & (32'hFFFF_FFFF >> (32 - wid[a]));
  endfunction
  // One-cycle update strobe; reports whether the phase fell back to the bare offset
  task automatic pulse_update(output logic [31:0] hit);
    hit = 32'h0;
    i_io_update <= 1'b1;
    repeat (12) begin
      @(posedge i_sys_clk);
      i_io_update <= 1'b0;
      if (o_phase === 14'h0100) hit = 32'h1;
    end
  endtask
  // Main sequence
  initial begin
    v = $urandom(87);
    repeat (2) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    chk(o_pll_bypass, 32'h1);
    for (int a = 0; a < 6; a++) begin
      rd(a);
      chk(q, 32'h0);
    end
    for (int r = 0; r < 3; r++)
      for (int a = 1; a < 6; a++) begin
        v = r ? $urandom : 32'hFFFF_FFFF;
        wr(a, v);
        if (a == 3) chk(o_amplitude_ramp_rate, v[7:0]);
        if (a == 2) chk(o_amplitude_scale, v[15:0]);
        rd(a);
        chk(q, expect_of(a, v));
      end
    for (int m = 0; m < 32; m++) begin
      wr(1, m << 3);
      chk(o_pll_mult, m[4:0]);
      chk(o_pll_bypass, m < 4 || m > 20);
    end
    wr(4, 32'h0004_0000);
    wr(5, 32'h0100);
    wr(0, 32'h0400);
    repeat (20) @(posedge i_sys_clk);
    chk(o_phase, 32'h0100);
    wr(0, 32'h2000);
    pulse_update(v);
    chk(v, 32'h1);
    wr(0, 32'h0100);
    pulse_update(v);
    chk(v, 32'h0);
    wr(3, 32'h1E, 1'b1);
    chk(o_amplitude_ramp_rate, 32'h1E);
    rd(3, 1'b1);
    chk(q, 32'h1E);
    wr(0, 32'h0200, 1'b1);
    three <= 1'b1;
    oe_seen <= 1'b0;
    rd(3);
    chk(q, 32'h1E);
    chk(oe_seen, 32'h0);
    wr(0, 32'h0);
    three <= 1'b0;
    oe_seen <= 1'b0;
    rd(3);
    chk(oe_seen, 32'h1);
    chk(q, 32'h1E);
    print_verdict;
  end
endmodule // tb_top

// ### hdl/ddsr_phase_acc.v
// Phase accumulator with hold-clear, update-driven auto-clear and phase offset
`timescale 1ns/10ps
module ddsr_phase_acc #(
  parameter ACC_W = 32,
  parameter OUT_W = 14
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst_b,
  // Control
  input wire i_clear_hold,
  input wire i_auto_clear,
  input wire i_update,
  // Words
  input wire [ACC_W-1:0] i_tuning_word,
  input wire [OUT_W-1:0] i_phase_offset,
  // Phase out
  output reg [OUT_W-1:0] o_phase
);

  reg [ACC_W-1:0] acc;

  // Accumulate; the held clear beats everything so no phase leaks out
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc <= {ACC_W{1'b0}};
    end else if (i_clear_hold) begin
      acc <= {ACC_W{1'b0}};
    end else if (i_auto_clear && i_update) begin
      acc <= {ACC_W{1'b0}};
    end else begin
      acc <= acc + i_tuning_word;
    end
  end

  // Truncated phase plus offset, registered
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_phase <= {OUT_W{1'b0}};
    end else begin
      o_phase <= acc[ACC_W-1:ACC_W-OUT_W] + i_phase_offset;
    end
  end

endmodule // ddsr_phase_acc

// ### hdl/ddsr_register_map.v
// Serially addressed configuration register bank of the DDS
`timescale 1ns/10ps
`include "ddsr_consts.vh"

// How it works
// - Multiplier field 4 to 20 multiplies the reference clock by that value.
// - Multiplier field 0 to 3 bypasses the multiplier; reference clock used directly.
// - Tuning word is 32 bits at serial address 4, bytes 7:0 up to 31:24.
// - Ramp rate is one full 8-bit register at serial address 3.
// - While clear-accumulator bit is set, the accumulator is held at zero.
// - With auto-clear set, each update strobe zeroes the accumulator for one cycle.
// - Bit-order bit set means serial data least significant bit first.
// - Input-only bit set makes the data pin input only; else bidirectional.
module ddsr_register_map #(
  parameter ACC_W = 32
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst_b,
  // Serial port pins
  input wire i_sclk,
  input wire i_cs_b,
  input wire i_sdio,
  output reg o_sdio,
  output wire o_sdio_oe_b,
  output reg o_sdo,
  input wire i_io_update,
  // Clock multiplier control
  output reg o_pll_bypass,
  output reg [4:0] o_pll_mult,
  // Core view of the bank
  output reg [15:0] o_amplitude_scale,
  output reg [7:0] o_amplitude_ramp_rate,
  output wire [13:0] o_phase
);

  localparam ST_INSTR = 1'b0;
  localparam ST_DATA = 1'b1;

  // Register bank
  reg [31:0] primary_control;
  reg [23:0] analog_clock_control;
  reg [15:0] amplitude_scale;
  reg [7:0] amplitude_ramp_rate;
  reg [31:0] frequency_tuning;
  reg [15:0] phase_offset;

  // Pin synchronisers and edge history
  reg [2:0] sclk_s;
  reg [1:0] cs_s;
  reg [1:0] sdio_s;
  reg [2:0] upd_s;

  // Serial engine
  reg state;
  reg [5:0] bit_cnt;
  reg [31:0] sh;
  reg rd_op;
  reg [4:0] addr;
  reg [31:0] rd_val;
  reg [31:0] next_sh;
  reg [31:0] wr_val;
  wire [5:0] width;
  wire lsb_first;
  wire sclk_rise;
  wire sclk_fall;
  wire update_pulse;
  wire [5:0] out_idx;
  wire [4:0] mult;

  // Width of a register at a serial address; the eight-bit instruction width when unmapped
  function [5:0] reg_width;
    input [4:0] a;
    begin
      case (a)
        `DDSR_ADDR_PRIMARY: reg_width = `DDSR_W_PRIMARY;
        `DDSR_ADDR_ANALOG: reg_width = `DDSR_W_ANALOG;
        `DDSR_ADDR_SCALE: reg_width = `DDSR_W_SCALE;
        `DDSR_ADDR_RAMP: reg_width = `DDSR_W_RAMP;
        `DDSR_ADDR_TUNING: reg_width = `DDSR_W_TUNING;
        `DDSR_ADDR_PHASE: reg_width = `DDSR_W_PHASE;
        default: reg_width = `DDSR_W_INSTR;
      endcase
    end
  endfunction

  // Read value at a serial address, right aligned
  function [31:0] reg_value;
    input [4:0] a;
    begin
      case (a)
        `DDSR_ADDR_PRIMARY: reg_value = primary_control;
        `DDSR_ADDR_ANALOG: reg_value = {8'h00, analog_clock_control};
        `DDSR_ADDR_SCALE: reg_value = {16'h0000, amplitude_scale};
        `DDSR_ADDR_RAMP: reg_value = {24'h00_0000, amplitude_ramp_rate};
        `DDSR_ADDR_TUNING: reg_value = frequency_tuning;
        `DDSR_ADDR_PHASE: reg_value = {16'h0000, phase_offset};
        default: reg_value = `DDSR_RST_32;
      endcase
    end
  endfunction

  // Two flops on every pin before use; third stage only for edges
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_s <= 3'h0;
      cs_s <= 2'h3;
      sdio_s <= 2'h0;
      upd_s <= 3'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], i_sclk};
      cs_s <= {cs_s[0], i_cs_b};
      sdio_s <= {sdio_s[0], i_sdio};
      upd_s <= {upd_s[1:0], i_io_update};
    end
  end

  assign sclk_rise = sclk_s[1] & ~sclk_s[2];
  assign sclk_fall = ~sclk_s[1] & sclk_s[2];
  assign update_pulse = upd_s[1] & ~upd_s[2];
  assign lsb_first = primary_control[`DDSR_BIT_LSB_FIRST];
  assign width = (state == ST_INSTR) ? `DDSR_W_INSTR : reg_width(addr);
  // Bit driven out: counts up from bit 0 or down from the top
  assign out_idx = lsb_first ? bit_cnt : (width - 6'h01 - bit_cnt);

  // Shift direction and the right-aligned word once a field is complete
  always @* begin
    if (lsb_first) begin
      next_sh = {sdio_s[1], sh[31:1]};
      wr_val = next_sh >> (6'h20 - width);
    end else begin
      next_sh = {sh[30:0], sdio_s[1]};
      wr_val = next_sh;
    end
  end

  // Frame engine: instruction byte then one register's worth of bits
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= ST_INSTR;
      bit_cnt <= 6'h00;
      sh <= `DDSR_RST_32;
      rd_op <= 1'b0;
      addr <= 5'h00;
      rd_val <= `DDSR_RST_32;
    end else if (cs_s[1]) begin
      // Deselect aborts any partial transfer
      state <= ST_INSTR;
      bit_cnt <= 6'h00;
    end else if (sclk_rise) begin
      sh <= next_sh;
      if (bit_cnt == width - 6'h01) begin
        bit_cnt <= 6'h00;
        case (state)
          ST_INSTR: begin
            state <= ST_DATA;
            rd_op <= wr_val[`DDSR_INSTR_READ];
            addr <= wr_val[`DDSR_INSTR_ADDR_HI:0];
            rd_val <= reg_value(wr_val[`DDSR_INSTR_ADDR_HI:0]);
          end
          default: begin
            state <= ST_INSTR;
          end
        endcase
      end else begin
        bit_cnt <= bit_cnt + 6'h01;
      end
    end
  end

  // Register writes land when the last data bit arrives
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      primary_control <= `DDSR_RST_32;
      analog_clock_control <= `DDSR_RST_24;
      amplitude_scale <= `DDSR_RST_16;
      amplitude_ramp_rate <= `DDSR_RST_8;
      frequency_tuning <= `DDSR_RST_32;
      phase_offset <= `DDSR_RST_16;
    end else if (!cs_s[1] && sclk_rise && state == ST_DATA && !rd_op && bit_cnt == width - 6'h01) begin
      case (addr)
        `DDSR_ADDR_PRIMARY: primary_control <= wr_val;
        `DDSR_ADDR_ANALOG: analog_clock_control <= wr_val[23:0];
        `DDSR_ADDR_SCALE: amplitude_scale <= wr_val[15:0];
        `DDSR_ADDR_RAMP: amplitude_ramp_rate <= wr_val[7:0];
        `DDSR_ADDR_TUNING: frequency_tuning <= wr_val;
        `DDSR_ADDR_PHASE: phase_offset <= wr_val[15:0] & `DDSR_PHASE_MASK;
        default: primary_control <= primary_control;
      endcase
    end
  end

  // Read bits change on the falling serial edge so the host samples on the rising one
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sdio <= 1'b0;
      o_sdo <= 1'b0;
    end else if (!cs_s[1] && sclk_fall && state == ST_DATA && rd_op) begin
      o_sdio <= rd_val[out_idx[4:0]];
      o_sdo <= rd_val[out_idx[4:0]];
    end
  end

  // Data pin driven only for reads in two-wire mode
  assign o_sdio_oe_b = ~(state == ST_DATA && rd_op && !cs_s[1] &&
                         !primary_control[`DDSR_BIT_INPUT_ONLY]);

  // Multiplier decode; registered for a clean analog-side control
  assign mult = analog_clock_control[`DDSR_MULT_HI:`DDSR_MULT_LO];
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pll_bypass <= 1'b1;
      o_pll_mult <= 5'h00;
      o_amplitude_scale <= `DDSR_RST_16;
      o_amplitude_ramp_rate <= `DDSR_RST_8;
    end else begin
      o_pll_bypass <= (mult < `DDSR_MULT_MIN) || (mult > `DDSR_MULT_MAX);
      o_pll_mult <= mult;
      o_amplitude_scale <= amplitude_scale;
      o_amplitude_ramp_rate <= amplitude_ramp_rate;
    end
  end

  // Accumulator driven by the bank
  ddsr_phase_acc #(
    .ACC_W(ACC_W),
    .OUT_W(`DDSR_PHASE_W)
  ) u_acc (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_clear_hold(primary_control[`DDSR_BIT_CLR_ACC]),
    .i_auto_clear(primary_control[`DDSR_BIT_AUTO_CLR]),
    .i_update(update_pulse),
    .i_tuning_word(frequency_tuning[ACC_W-1:0]),
    .i_phase_offset(phase_offset[`DDSR_PHASE_W-1:0]),
    .o_phase(o_phase)
  );

endmodule // ddsr_register_map

// ### pkg/ddsr_consts.vh
// Register map, field positions and serial framing constants of the DDS register bank
`ifndef DDSR_CONSTS_VH
`define DDSR_CONSTS_VH

// Serial addresses of the registers
`define DDSR_ADDR_PRIMARY 5'h00
`define DDSR_ADDR_ANALOG 5'h01
`define DDSR_ADDR_SCALE 5'h02
`define DDSR_ADDR_RAMP 5'h03
`define DDSR_ADDR_TUNING 5'h04
`define DDSR_ADDR_PHASE 5'h05

// Register widths in bits
`define DDSR_W_PRIMARY 6'h20
`define DDSR_W_ANALOG 6'h18
`define DDSR_W_SCALE 6'h10
`define DDSR_W_RAMP 6'h08
`define DDSR_W_TUNING 6'h20
`define DDSR_W_PHASE 6'h10
`define DDSR_W_INSTR 6'h08

// Reset values
`define DDSR_RST_32 32'h0000_0000
`define DDSR_RST_24 24'h00_0000
`define DDSR_RST_16 16'h0000
`define DDSR_RST_8 8'h00

// Primary control fields
`define DDSR_BIT_LSB_FIRST 8
`define DDSR_BIT_INPUT_ONLY 9
`define DDSR_BIT_CLR_ACC 10
`define DDSR_BIT_AUTO_CLR 13

// Analog clock control: reference multiplier field and limits
`define DDSR_MULT_HI 7
`define DDSR_MULT_LO 3
`define DDSR_MULT_MIN 5'h04
`define DDSR_MULT_MAX 5'h14

// Phase offset: 14 value bits
`define DDSR_PHASE_MASK 16'h3FFF
`define DDSR_PHASE_W 14

// Instruction byte fields
`define DDSR_INSTR_READ 7
`define DDSR_INSTR_ADDR_HI 4

`endif
